// ==== rtl/dac_frame_pkg.sv ====
// Constants shared by the serial frame receiver and its crossing.
// Assumes the link clock is a free pin clock driven by the host.
`default_nettype none
package dac_frame_pkg;
  localparam int          FRAME_BITS      = 24;
  localparam int          CNT_W           = 5;
  localparam logic [4:0]  CNT_ZERO        = 5'h00;
  localparam logic [4:0]  CNT_ONE         = 5'h01;
  localparam logic [23:0] SHIFT_RESET     = 24'h000000;
  localparam int          SCLK_MAX_MHZ    = 50;
  localparam int          SYS_CLK_MHZ     = 125;
  localparam logic [1:0]  SYNC_RESET      = 2'h0;
endpackage
`default_nettype wire

// ==== rtl/dac_frame_toggle_sync.sv ====
// Two-flop level synchroniser with an edge detector behind it.
// Assumes the input is a toggle level from another clock domain.
`timescale 1ns/1ns
`default_nettype none
module dac_frame_toggle_sync
  import dac_frame_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_toggle,
  output logic      o_pulse
);
  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic       last_q;
  logic       last_d;

  always_comb begin
    sync_d = {sync_q[0], i_toggle};
    last_d = sync_q[1];
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sync_q <= SYNC_RESET;
      last_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // Only the second flop is compared; the first feeds nothing else
  assign o_pulse = sync_q[1] ^ last_q;
endmodule
`default_nettype wire

// ==== rtl/dac_serial_frame_receiver.sv ====
// Serial input front end: 24-bit frame capture on the link clock,
// completed words handed to the system clock domain.
// Assumes the host drives sync, serial clock and data as a master.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Sync falling arms the shift register; sync high ignores all input.
// - After sync falls one bit is taken per falling edge, 24 in all.
// - Sync rising before the 24th edge drops the frame with no action.
// - A 24-bit shift register samples data on the falling clock edge.
// - The reference pin is an input by default, output only if selected.
module dac_serial_frame_receiver
  import dac_frame_pkg::*;
#(
  parameter int WORD_BITS = FRAME_BITS
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_link_sclk,
  input  wire logic                 i_sync_n,
  input  wire logic                 i_din,
  input  wire logic                 i_int_ref_select,
  input  wire logic                 i_int_ref_level,
  input  wire logic                 i_shared_reference_pin_in,
  output logic                      o_shared_reference_pin_out,
  output logic                      o_shared_reference_pin_oe,
  output logic                      o_ref_in_level,
  output logic                      o_link_active,
  output logic [WORD_BITS-1:0]      o_word,
  output logic                      o_word_valid
);

  // ------------------------------------------------------------------
  // Link domain capture
  // ------------------------------------------------------------------
  // Sync acts as an asynchronous clear of the frame logic, so a frame
  // aborted between clock edges ends even if the serial clock stops.
  // The cost is that sync must not glitch high while a frame is being sent.
  typedef enum logic [0:0] {
    FRAME_SHIFTING = 1'b0,
    FRAME_FULL     = 1'b1
  } frame_state_t;

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WORD_BITS - 1);

  logic                 frame_rst;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shift_d;
  logic [CNT_W-1:0]     cnt_q;
  logic [CNT_W-1:0]     cnt_d;
  frame_state_t         state_q;
  frame_state_t         state_d;
  logic                 word_take;
  logic [WORD_BITS-1:0] word_q;
  logic [WORD_BITS-1:0] word_d;
  logic                 tog_q;
  logic                 tog_d;
  logic                 last_edge;

  assign frame_rst = i_sync_n | i_reset;
  assign last_edge = (cnt_q == CNT_LAST);
  // Only a frame still held low at its last edge yields a word
  assign word_take = (state_q == FRAME_SHIFTING) && last_edge
                     && !i_sync_n;

  // Bits after the last one land nowhere: the full state freezes the
  // register and the counter until sync clears them.
  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    state_d = state_q;
    unique case (state_q)
      FRAME_SHIFTING: begin
        shift_d = {shift_q[WORD_BITS-2:0], i_din};
        cnt_d   = cnt_q + CNT_ONE;
        if (last_edge) begin
          state_d = FRAME_FULL;
        end
      end
      FRAME_FULL: begin
        // Extra bits of an overlong frame are dropped
        state_d = FRAME_FULL;
      end
    endcase
  end

  always_ff @(negedge i_link_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      shift_q <= SHIFT_RESET[WORD_BITS-1:0];
      cnt_q   <= CNT_ZERO;
      state_q <= FRAME_SHIFTING;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      state_q <= state_d;
    end
  end

  // Completed word held stable across the crossing; only a full frame
  // reaches here, so an aborted frame produces no toggle.
  always_comb begin
    word_d = word_q;
    tog_d  = tog_q;
    if (word_take) begin
      word_d = {shift_q[WORD_BITS-2:0], i_din};
      tog_d  = ~tog_q;
    end
  end

  always_ff @(negedge i_link_sclk or posedge i_reset) begin
    if (i_reset) begin
      word_q <= SHIFT_RESET[WORD_BITS-1:0];
      tog_q  <= 1'b0;
    end else begin
      word_q <= word_d;
      tog_q  <= tog_d;
    end
  end

  // ------------------------------------------------------------------
  // System domain handover
  // ------------------------------------------------------------------
  // Toggle crossing; word_q is stable for a full frame (>= 24 link
  // clocks) after each toggle, far longer than the sync latency.
  logic                 new_word;
  logic [WORD_BITS-1:0] out_q;
  logic [WORD_BITS-1:0] out_d;
  logic                 vld_q;
  logic                 vld_d;
  logic [1:0]           act_q;
  logic [1:0]           act_d;
  logic [1:0]           ref_q;
  logic [1:0]           ref_d;

  // The pulse only says a new word is waiting; the word itself is not
  // resynchronised, which is safe only because it holds for a frame.
  // Frames shorter than the crossing latency cannot occur.

  dac_frame_toggle_sync u_word_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_toggle  (tog_q),
    .o_pulse   (new_word)
  );

  // Word and strobe move together: the strobe is the registered
  // crossing pulse, so the word is settled when it shows.
  always_comb begin
    out_d = out_q;
    vld_d = 1'b0;
    if (new_word) begin
      out_d = word_q;
      vld_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      out_q <= SHIFT_RESET[WORD_BITS-1:0];
      vld_q <= 1'b0;
    end else begin
      out_q <= out_d;
      vld_q <= vld_d;
    end
  end

  assign o_word       = out_q;
  assign o_word_valid = vld_q;

  // ------------------------------------------------------------------
  // Pin level synchronisers
  // ------------------------------------------------------------------
  // Sync and the reference pin change with no regard to the system
  // clock; only the second flop of each pair is read.
  always_comb begin
    act_d = {act_q[0], ~i_sync_n};
    ref_d = {ref_q[0], i_shared_reference_pin_in};
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      act_q <= SYNC_RESET;
      ref_q <= SYNC_RESET;
    end else begin
      act_q <= act_d;
      ref_q <= ref_d;
    end
  end

  assign o_link_active  = act_q[1];
  assign o_ref_in_level = ref_q[1];

  // ------------------------------------------------------------------
  // Shared reference pin
  // ------------------------------------------------------------------
  // Reset leaves the pin an input; it drives one clock after internal
  // reference is chosen, and its level follows on the same clock.
  logic                 drive_q;
  logic                 drive_d;
  logic                 level_q;
  logic                 level_d;

  always_comb begin
    drive_d = i_int_ref_select;
    level_d = i_int_ref_select & i_int_ref_level;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      drive_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      drive_q <= drive_d;
      level_q <= level_d;
    end
  end

  assign o_shared_reference_pin_oe  = drive_q;
  assign o_shared_reference_pin_out = level_q;
endmodule
`default_nettype wire

// ==== bench/dac_frame_checker.sv ====
// Port-level checks for the serial frame receiver.
// Assumes it is bound to every receiver instance.
`timescale 1ns/1ns
`default_nettype none
module dac_frame_checker #(parameter int WORD_BITS = 24) (
  input wire logic                 i_sys_clk,
  input wire logic                 i_reset,
  input wire logic                 i_int_ref_select,
  input wire logic                 i_int_ref_level,
  input wire logic                 o_shared_reference_pin_out,
  input wire logic                 o_shared_reference_pin_oe,
  input wire logic                 o_link_active,
  input wire logic [WORD_BITS-1:0] o_word,
  input wire logic                 o_word_valid
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence word_done;
    $rose(o_word_valid);
  endsequence
  a_pin_role: assert property (
    1'b1 |=> o_shared_reference_pin_oe == $past(i_int_ref_select))
    else $error("ref pin direction wrong");
  a_pin_level: assert property (
    o_shared_reference_pin_oe |->
    o_shared_reference_pin_out == $past(i_int_ref_level))
    else $error("ref pin level wrong");
  a_valid_once: assert property (word_done |=> !o_word_valid)
    else $error("word presented twice");
  a_word_hold: assert property (!o_word_valid |-> $stable(o_word))
    else $error("word moved without valid");
  a_frame_live: assert property (
    word_done |-> $past(o_link_active, 8))
    else $error("word without frame");
  a_idle_quiet: assert property (
    !o_link_active [*8] |=> !$rose(o_word_valid))
    else $error("word while idle");
endmodule
bind dac_serial_frame_receiver dac_frame_checker
  #(.WORD_BITS(WORD_BITS)) chk_u (.*);
`default_nettype wire

// ==== bench/frame_host_model.sv ====
// Host serial master driving sync, serial clock and data.
// Clock idles high and only runs inside a frame.
`timescale 1ns/1ns
`default_nettype none
module frame_host_model (
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_din
);
  initial begin
    o_sclk = 1'b1;
    o_sync_n = 1'b1;
    o_din = 1'b0;
  end
  // Sync level is a task input so a frame can run with sync held high
  task automatic send(input int n, input logic [29:0] d, input logic s);
    o_sync_n = s;
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      o_din = d[i];
      #15 o_sclk = 1'b0;
      #15 o_sclk = 1'b1;
    end
    o_sync_n = 1'b1;
    o_din = ~o_din;
    #20;
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the serial frame receiver.
// Assumes the host model owns the link pins.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk, rst, sel, lvl, pin, sclk, sync_n, din, oe, pout;
  logic        ref_lvl, act, valid;
  logic [23:0] word;
  int          error_cnt = 0, checks_done = 0, vcnt = 0;
  localparam logic [29:0] LONG = 30'h1234567b;
  always #4 clk = ~clk;
  always @(posedge clk) if (valid === 1'b1) vcnt <= vcnt + 1;
  frame_host_model host_u (.o_sclk(sclk), .o_sync_n(sync_n), .o_din(din));
  dac_serial_frame_receiver dut_u (.i_sys_clk(clk), .i_reset(rst),
    .i_link_sclk(sclk), .i_sync_n(sync_n), .i_din(din),
    .i_int_ref_select(sel), .i_int_ref_level(lvl),
    .i_shared_reference_pin_in(pin), .o_shared_reference_pin_out(pout),
    .o_shared_reference_pin_oe(oe), .o_ref_in_level(ref_lvl),
    .o_link_active(act), .o_word(word), .o_word_valid(valid));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input int n, input logic [29:0] d, input logic s,
                      output logic [23:0] c);
    int   v0;
    logic want_act;
    v0 = vcnt;
    want_act = ~s;
    fork
      host_u.send(n, d, s);
      begin
        repeat (10) @(negedge clk);
        check(act, want_act);
      end
    join
    repeat (10) @(negedge clk);
    check(act, 1'b0);
    c = 24'(vcnt - v0);
  endtask
  task automatic t_ref;
    @(negedge clk);
    check(oe, 24'h0);
    for (int i = 0; i < 4; i++) begin
      sel = i[1];
      lvl = i[0];
      pin = ~i[0];
      repeat (4) @(negedge clk);
      check(oe, sel);
      check(pout, sel & lvl);
      check(ref_lvl, pin);
    end
    sel = 1'b0;
  endtask
  task automatic t_frames;
    logic [23:0] c;
    xfer(24, 30'h00a5c3f1, 1'b0, c);
    check(c, 24'h1);
    check(word, 24'ha5c3f1);
    xfer(10, 30'h3ff, 1'b0, c);
    check(c, 24'h0);
    check(word, 24'ha5c3f1);
    xfer(24, 30'h123456, 1'b1, c);
    check(c, 24'h0);
    xfer(30, LONG, 1'b0, c);
    check(c, 24'h1);
    check(word, LONG[29:6]);
  endtask
  task automatic test_done;
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    sel = 1'b0;
    lvl = 1'b0;
    pin = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_ref;
    t_frames;
    test_done;
  end
  // Whole run needs about 3.4 us
  initial begin
    #20000;
    error_cnt++;
    test_done;
  end
endmodule
`default_nettype wire
